// file: rtl/tcpe_pkg.sv
// Package: register map, field positions and reset values of the channel block
// Functional notes
// - Bit 3 sets complementary output active level
// - Bit 1 sets main output active level
// - Both polarity bits zero: rising edge, uninverted
// - Main bit only: falling edge, input inverted
// - Both set: both edges; 10 reserved
// - Protection level 11 or 10 locks polarity
// - Bit 0 enables the channel
// - Counter read returns live 16-bit count
// - Counter write loads the running counter
// - Capture prescaler held reset while disabled
// - Mode field writable only while disabled
package tcpe_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] TCPE_OFS_CHCTL = 8'h20;
    localparam logic [7:0] TCPE_OFS_COUNT = 8'h24;
    localparam logic [7:0] TCPE_OFS_MODE = 8'h18;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TCPE_BIT_ON = 0;
    localparam int TCPE_BIT_MAINP = 1;
    localparam int TCPE_BIT_COMPP = 3;
    localparam int TCPE_BIT_PSC_LO = 2;
    localparam int TCPE_CNT_W = 16;
    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [3:0] TCPE_RST_CHCTL = 4'h0;
    localparam logic [15:0] TCPE_RST_COUNT = 16'h0000;
    localparam logic [3:0] TCPE_RST_MODE = 4'h0;
    localparam logic [1:0] TCPE_MODE_OUT = 2'h0;
    localparam logic [1:0] TCPE_MODE_IN = 2'h1;
    localparam logic [1:0] TCPE_LVL_LOCK_HI = 2'h3;
    localparam logic [1:0] TCPE_LVL_LOCK_MID = 2'h2;

    typedef enum logic [1:0] {
        TCPE_EDGE_RISE = 2'b00,
        TCPE_EDGE_FALL = 2'b01,
        TCPE_EDGE_RSVD = 2'b10,
        TCPE_EDGE_BOTH = 2'b11
    } tcpe_edge_t;
endpackage : tcpe_pkg

// file: rtl/tcpe_edge_if.sv
// Interface: edge selection carried from the register file to the edge unit
`timescale 1ns/1ps
`default_nettype none
interface tcpe_edge_if;
    logic [1:0] edge_sel;
    logic enable;
    logic [1:0] psc_sel;
    logic filt_in;
    logic edge_evt;
    logic capture_evt;
    logic cond_in;
    modport ctrl (output edge_sel, output enable, output psc_sel,
        output filt_in, input edge_evt, input capture_evt, input cond_in);
    modport unit (input edge_sel, input enable, input psc_sel,
        input filt_in, output edge_evt, output capture_evt, output cond_in);
endinterface : tcpe_edge_if
`default_nettype wire

// file: rtl/tcpe_edge_unit.sv
// Module: input polarity, edge detection and capture edge prescaler
`timescale 1ns/1ps
`default_nettype none
module tcpe_edge_unit
    import tcpe_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    tcpe_edge_if.unit eif
);
    logic prev_reg;
    logic [2:0] psc_cnt_reg;
    logic rise;
    logic fall;
    logic edge_hit;
    logic [2:0] psc_lim;

    // Conditioned level: inverted only for falling-edge selection
    assign eif.cond_in = (eif.edge_sel == TCPE_EDGE_FALL) ? ~eif.filt_in
                                                         : eif.filt_in;
    assign rise = eif.filt_in & ~prev_reg;
    assign fall = ~eif.filt_in & prev_reg;

    // Active edge by polarity pair; reserved code gives no edge
    always_comb begin
        case (eif.edge_sel)
            TCPE_EDGE_RISE: edge_hit = rise;
            TCPE_EDGE_FALL: edge_hit = fall;
            TCPE_EDGE_BOTH: edge_hit = rise | fall;
            default: edge_hit = 1'b0;
        endcase
    end
    assign eif.edge_evt = edge_hit & eif.enable;

    // Divide ratio 1, 2, 4 or 8 edges
    always_comb begin
        case (eif.psc_sel)
            2'h0: psc_lim = 3'h0;
            2'h1: psc_lim = 3'h1;
            2'h2: psc_lim = 3'h3;
            default: psc_lim = 3'h7;
        endcase
    end
    assign eif.capture_evt = eif.edge_evt && (psc_cnt_reg >= psc_lim);

    // Edge history
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= eif.filt_in;
        end
    end

    // Prescaler kept cleared while the channel is off
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !eif.enable) begin
            psc_cnt_reg <= 3'h0;
        end else if (eif.capture_evt) begin
            psc_cnt_reg <= 3'h0;
        end else if (eif.edge_evt) begin
            psc_cnt_reg <= psc_cnt_reg + 3'h1;
        end
    end

    // Prescaler must read zero in the cycle after every disabled cycle
    property p_psc_off;
        @(posedge clk_sys) disable iff (!rst_n)
        !eif.enable |=> psc_cnt_reg == 3'h0;
    endproperty
    a_psc_off: assert property (p_psc_off)
        else $error("prescaler not held while channel off");
endmodule : tcpe_edge_unit
`default_nettype wire

// file: rtl/tcpe_channel.sv
// Module: channel enable, polarity control and counter register block
`timescale 1ns/1ps
`default_nettype none
module tcpe_channel
    import tcpe_pkg::*;
#(
    parameter int CNT_W = TCPE_CNT_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic [1:0] protection_level,
    input wire logic count_tick,
    input wire logic filtered_channel_input,
    input wire logic main_ref,
    output logic main_out,
    output logic complementary_out,
    output logic filtered_input_edge_signal,
    output logic capture_pulse,
    output logic channel_on_out
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic channel_on_reg;
    logic main_polarity_reg;
    logic complementary_output_polarity_reg;
    logic [1:0] channel_io_mode_reg;
    logic [1:0] capture_edge_prescaler_reg;
    logic [CNT_W-1:0] count_value_reg;
    logic pol_locked;
    logic wr_chctl;
    logic wr_count;
    logic wr_mode;
    logic in_mode;
    tcpe_edge_if eif();

    assign wr_chctl = wr_en && (addr == TCPE_OFS_CHCTL);
    assign wr_count = wr_en && (addr == TCPE_OFS_COUNT);
    assign wr_mode = wr_en && (addr == TCPE_OFS_MODE);
    assign in_mode = (channel_io_mode_reg == TCPE_MODE_IN);
    // Locked at protection levels 11 and 10
    assign pol_locked = (protection_level == TCPE_LVL_LOCK_HI) ||
                        (protection_level == TCPE_LVL_LOCK_MID);

    // ------------------------------------------------------------
    // Enable bit, always writable
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            channel_on_reg <= TCPE_RST_CHCTL[TCPE_BIT_ON];
        end else if (wr_chctl) begin
            channel_on_reg <= wdata[TCPE_BIT_ON];
        end
    end

    // Polarity bits; write dropped silently under protection
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            main_polarity_reg <= TCPE_RST_CHCTL[TCPE_BIT_MAINP];
            complementary_output_polarity_reg <=
                TCPE_RST_CHCTL[TCPE_BIT_COMPP];
        end else if (wr_chctl && !pol_locked) begin
            main_polarity_reg <= wdata[TCPE_BIT_MAINP];
            complementary_output_polarity_reg <= wdata[TCPE_BIT_COMPP];
        end
    end

    // Mode field changes only while the channel is off, so a live
    // capture cannot see its source switch under it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            channel_io_mode_reg <= TCPE_RST_MODE[1:0];
            capture_edge_prescaler_reg <= TCPE_RST_MODE[3:2];
        end else if (wr_mode) begin
            if (!channel_on_reg) begin
                channel_io_mode_reg <= wdata[1:0];
            end
            capture_edge_prescaler_reg <=
                wdata[TCPE_BIT_PSC_LO+1:TCPE_BIT_PSC_LO];
        end
    end

    // ------------------------------------------------------------
    // Counter: software load has priority over the tick
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            count_value_reg <= TCPE_RST_COUNT[CNT_W-1:0];
        end else if (wr_count) begin
            count_value_reg <= wdata[CNT_W-1:0];
        end else if (count_tick) begin
            count_value_reg <= count_value_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Read port: data in the cycle after the strobe, zero elsewhere
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata <= 32'h00000000;
        end else if (rd_en) begin
            case (addr)
                TCPE_OFS_CHCTL: rdata <= {28'h0000000,
                    complementary_output_polarity_reg, 1'b0,
                    main_polarity_reg, channel_on_reg};
                TCPE_OFS_COUNT: rdata <= {{(32-CNT_W){1'b0}},
                    count_value_reg};
                TCPE_OFS_MODE: rdata <= {28'h0000000,
                    capture_edge_prescaler_reg, channel_io_mode_reg};
                default: rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // Edge unit hookup
    // ------------------------------------------------------------
    assign eif.edge_sel = {complementary_output_polarity_reg,
                           main_polarity_reg};
    assign eif.enable = channel_on_reg && in_mode;
    assign eif.psc_sel = capture_edge_prescaler_reg;
    assign eif.filt_in = filtered_channel_input;

    tcpe_edge_unit u_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .eif(eif)
    );

    // Registered outputs; main and complementary outputs idle inactive when channel is off
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            main_out <= 1'b0;
            complementary_out <= 1'b0;
            filtered_input_edge_signal <= 1'b0;
            capture_pulse <= 1'b0;
            channel_on_out <= 1'b0;
        end else begin
            main_out <= (channel_on_reg && !in_mode)
                ? (main_ref ^ main_polarity_reg) : main_polarity_reg;
            complementary_out <= (channel_on_reg && !in_mode)
                ? (~main_ref ^ complementary_output_polarity_reg)
                : complementary_output_polarity_reg;
            filtered_input_edge_signal <= eif.cond_in;
            capture_pulse <= eif.capture_evt;
            channel_on_out <= channel_on_reg;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_pol_lock;
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_chctl && pol_locked) |=> $stable(main_polarity_reg) &&
            $stable(complementary_output_polarity_reg);
    endproperty
    a_pol_lock: assert property (p_pol_lock)
        else $error("polarity changed while protected");

    property p_cnt_load;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_count |=> count_value_reg == $past(wdata[CNT_W-1:0]);
    endproperty
    a_cnt_load: assert property (p_cnt_load)
        else $error("counter not loaded by write");

    property p_cnt_read;
        @(posedge clk_sys) disable iff (!rst_n)
        (rd_en && addr == TCPE_OFS_COUNT) |=>
            rdata == {{(32-CNT_W){1'b0}}, $past(count_value_reg)};
    endproperty
    a_cnt_read: assert property (p_cnt_read)
        else $error("counter read wrong");

    property p_mode_lock;
        @(posedge clk_sys) disable iff (!rst_n)
        channel_on_reg |=> $stable(channel_io_mode_reg);
    endproperty
    a_mode_lock: assert property (p_mode_lock)
        else $error("mode changed while channel on");

    property p_enable_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_chctl |=> ##1 channel_on_out == $past(wdata[TCPE_BIT_ON], 2);
    endproperty
    a_enable_wr: assert property (p_enable_wr)
        else $error("enable bit not followed");

    property p_main_pol;
        @(posedge clk_sys) disable iff (!rst_n)
        (channel_on_reg && !in_mode) |=>
            main_out == ($past(main_ref) ^ $past(main_polarity_reg));
    endproperty
    a_main_pol: assert property (p_main_pol)
        else $error("main output polarity wrong");

    property p_comp_pol;
        @(posedge clk_sys) disable iff (!rst_n)
        (channel_on_reg && !in_mode) |=> complementary_out ==
            (~$past(main_ref) ^ $past(complementary_output_polarity_reg));
    endproperty
    a_comp_pol: assert property (p_comp_pol)
        else $error("complementary output polarity wrong");

    property p_fall_inv;
        @(posedge clk_sys) disable iff (!rst_n)
        (eif.edge_sel == TCPE_EDGE_FALL) |=>
            filtered_input_edge_signal == !$past(filtered_channel_input);
    endproperty
    a_fall_inv: assert property (p_fall_inv)
        else $error("falling selection not inverted");

    property p_rise_plain;
        @(posedge clk_sys) disable iff (!rst_n)
        (eif.edge_sel != TCPE_EDGE_FALL) |=>
            filtered_input_edge_signal == $past(filtered_channel_input);
    endproperty
    a_rise_plain: assert property (p_rise_plain)
        else $error("input inverted wrongly");

    property p_reset_zero;
        @(posedge clk_sys) !rst_n |=> count_value_reg == '0 &&
            !channel_on_reg && !main_polarity_reg;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("reset values not zero");

    // Writes that pass the lock must land in both polarity bits
    property p_pol_write;
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_chctl && !pol_locked) |=>
            main_polarity_reg == $past(wdata[TCPE_BIT_MAINP]) &&
            complementary_output_polarity_reg ==
            $past(wdata[TCPE_BIT_COMPP]);
    endproperty
    a_pol_write: assert property (p_pol_write)
        else $error("polarity write not taken");

    property p_mode_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_mode && !channel_on_reg) |=>
            channel_io_mode_reg == $past(wdata[1:0]);
    endproperty
    a_mode_wr: assert property (p_mode_wr)
        else $error("mode write lost while channel off");

    // Capture paths judged at unit prescale, where every edge fires;
    // the input's own history stands in for the edge unit's flop
    property p_rise_cap;
        @(posedge clk_sys) disable iff (!rst_n)
        (eif.enable && eif.psc_sel == 2'h0 &&
            eif.edge_sel == TCPE_EDGE_RISE && filtered_channel_input &&
            !$past(filtered_channel_input)) |=> capture_pulse;
    endproperty
    a_rise_cap: assert property (p_rise_cap)
        else $error("rising edge not captured");

    property p_fall_cap;
        @(posedge clk_sys) disable iff (!rst_n)
        (eif.enable && eif.psc_sel == 2'h0 &&
            eif.edge_sel == TCPE_EDGE_FALL && !filtered_channel_input &&
            $past(filtered_channel_input)) |=> capture_pulse;
    endproperty
    a_fall_cap: assert property (p_fall_cap)
        else $error("falling edge not captured");

    property p_both_cap;
        @(posedge clk_sys) disable iff (!rst_n)
        (eif.enable && eif.psc_sel == 2'h0 &&
            eif.edge_sel == TCPE_EDGE_BOTH &&
            filtered_channel_input != $past(filtered_channel_input))
            |=> capture_pulse;
    endproperty
    a_both_cap: assert property (p_both_cap)
        else $error("edge missed with both edges selected");

    // Reserved polarity pair must never produce a capture
    property p_rsvd_quiet;
        @(posedge clk_sys) disable iff (!rst_n)
        (eif.edge_sel == TCPE_EDGE_RSVD) |=> !capture_pulse;
    endproperty
    a_rsvd_quiet: assert property (p_rsvd_quiet)
        else $error("capture on reserved polarity pair");

    // Disabled or output mode: the capture path stays silent
    property p_off_quiet;
        @(posedge clk_sys) disable iff (!rst_n)
        !eif.enable |=> !capture_pulse;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("capture while channel inactive");

    c_locked_wr: cover property (@(posedge clk_sys) wr_chctl && pol_locked);
    c_capture: cover property (@(posedge clk_sys) capture_pulse);
    c_cnt_wr: cover property (@(posedge clk_sys) wr_count && count_tick);
    c_both: cover property (@(posedge clk_sys)
        eif.edge_sel == TCPE_EDGE_BOTH && eif.edge_evt);
endmodule : tcpe_channel
`default_nettype wire

// file: sim/testbench.sv
// Testbench: registers, polarity, counter and capture path of the channel
`timescale 1ns/1ps
`default_nettype none
module testbench
    import tcpe_pkg::*;
();
    logic clk_sys, rst_n, wr_en, rd_en, count_tick, main_ref;
    logic filtered_channel_input, main_out, complementary_out;
    logic filtered_input_edge_signal, capture_pulse, channel_on_out;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, rd_val;
    logic [1:0] protection_level;
    int bad_count = 0;
    int tests_run = 0;
    int pulses = 0;
    int cycles = 0;
    int p0;

    tcpe_channel uut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .protection_level(protection_level), .count_tick(count_tick),
        .filtered_channel_input(filtered_channel_input),
        .main_ref(main_ref), .main_out(main_out),
        .complementary_out(complementary_out),
        .filtered_input_edge_signal(filtered_input_edge_signal),
        .capture_pulse(capture_pulse), .channel_on_out(channel_on_out));

    // ------------------------------------------------------------
    // Clock, pulse tally and hang guard
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Sampled on the edge, so a one-cycle pulse is counted exactly once
    always @(posedge clk_sys) begin
        if (capture_pulse === 1'b1) pulses <= pulses + 1;
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            bad_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got,
                exp);
        end
    endtask : chk_reg

    task chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got,
                exp);
        end
    endtask : chk_bit

    // ------------------------------------------------------------
    // Bus and stimulus helpers
    // ------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task rd(input logic [7:0] a);
        @(posedge clk_sys);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 rd_val = rdata;
    endtask : rd

    task settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : settle

    // Long enough for the registered edge pulse to be tallied
    task set_in(input logic lvl);
        @(posedge clk_sys);
        filtered_channel_input <= lvl;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : set_in

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        rd(TCPE_OFS_CHCTL);
        chk_reg(rd_val, 32'h0000_0000);
        rd(TCPE_OFS_COUNT);
        chk_reg(rd_val, 32'h0000_0000);
        chk_bit(channel_on_out, 1'b0);
        chk_bit(main_out, 1'b0);
        chk_bit(complementary_out, 1'b0);
    endtask : t_reset

    task t_output;
        @(posedge clk_sys);
        main_ref <= 1'b1;
        wr(TCPE_OFS_CHCTL, 32'h0000_0001);
        settle();
        chk_bit(channel_on_out, 1'b1);
        chk_bit(main_out, 1'b1);
        chk_bit(complementary_out, 1'b0);
        wr(TCPE_OFS_CHCTL, 32'h0000_000B);
        settle();
        chk_bit(main_out, 1'b0);
        chk_bit(complementary_out, 1'b1);
        @(posedge clk_sys);
        main_ref <= 1'b0;
        settle();
        chk_bit(main_out, 1'b1);
        chk_bit(complementary_out, 1'b0);
        wr(TCPE_OFS_CHCTL, 32'h0000_0000);
        settle();
        chk_bit(channel_on_out, 1'b0);
    endtask : t_output

    // Enable is never locked, only the two polarity bits
    task t_lock;
        wr(TCPE_OFS_CHCTL, 32'h0000_000B);
        protection_level <= 2'h3;
        wr(TCPE_OFS_CHCTL, 32'h0000_0001);
        rd(TCPE_OFS_CHCTL);
        chk_reg(rd_val, 32'h0000_000B);
        protection_level <= 2'h2;
        wr(TCPE_OFS_CHCTL, 32'h0000_0000);
        rd(TCPE_OFS_CHCTL);
        chk_reg(rd_val, 32'h0000_000A);
        protection_level <= 2'h1;
        wr(TCPE_OFS_CHCTL, 32'h0000_0000);
        rd(TCPE_OFS_CHCTL);
        chk_reg(rd_val, 32'h0000_0000);
        protection_level <= 2'h0;
    endtask : t_lock

    task t_count;
        wr(TCPE_OFS_COUNT, 32'h0000_1234);
        rd(TCPE_OFS_COUNT);
        chk_reg(rd_val, 32'h0000_1234);
        repeat (3) begin
            @(posedge clk_sys);
            count_tick <= 1'b1;
            @(posedge clk_sys);
            count_tick <= 1'b0;
        end
        rd(TCPE_OFS_COUNT);
        chk_reg(rd_val, 32'h0000_1237);
        // Tick held high across the write: the load must win
        @(posedge clk_sys);
        count_tick <= 1'b1;
        wr(TCPE_OFS_COUNT, 32'h0000_00AB);
        count_tick <= 1'b0;
        rd(TCPE_OFS_COUNT);
        chk_reg(rd_val, 32'h0000_00AB);
        wr(8'h30, 32'h0000_00FF);
        rd(8'h30);
        chk_reg(rd_val, 32'h0000_0000);
    endtask : t_count

    // Code is {complementary, main} polarity
    task t_input(input logic [1:0] mode, input logic [1:0] code,
        input int rise_n, input int fall_n, input logic inv);
        wr(TCPE_OFS_CHCTL, 32'h0000_0000);
        set_in(1'b0);
        wr(TCPE_OFS_MODE, {30'h0, mode});
        wr(TCPE_OFS_CHCTL, {28'h0, code[1], 1'b0, code[0], 1'b1});
        p0 = pulses;
        set_in(1'b1);
        chk_reg(32'(pulses - p0), 32'(rise_n));
        if (mode == TCPE_MODE_IN) begin
            chk_bit(filtered_input_edge_signal, ~inv);
        end
        p0 = pulses;
        set_in(1'b0);
        chk_reg(32'(pulses - p0), 32'(fall_n));
        if (mode == TCPE_MODE_IN) begin
            chk_bit(filtered_input_edge_signal, inv);
        end
    endtask : t_input

    // Mode change refused while the channel is on
    task t_mode_lock;
        wr(TCPE_OFS_MODE, 32'h0000_0000);
        rd(TCPE_OFS_MODE);
        chk_reg(rd_val, 32'h0000_0001);
    endtask : t_mode_lock

    task t_presc;
        for (int psc = 0; psc < 4; psc++) begin
            wr(TCPE_OFS_CHCTL, 32'h0000_0000);
            wr(TCPE_OFS_MODE, 32'(psc * 4 + 1));
            wr(TCPE_OFS_CHCTL, 32'h0000_0001);
            p0 = pulses;
            repeat (8) begin
                set_in(1'b1);
                set_in(1'b0);
            end
            chk_reg(32'(pulses - p0), 32'(8 >> psc));
        end
        // One edge, a disable, one more edge: a stale count would fire
        wr(TCPE_OFS_CHCTL, 32'h0000_0000);
        wr(TCPE_OFS_MODE, 32'h0000_0005);
        wr(TCPE_OFS_CHCTL, 32'h0000_0001);
        p0 = pulses;
        set_in(1'b1);
        set_in(1'b0);
        wr(TCPE_OFS_CHCTL, 32'h0000_0000);
        wr(TCPE_OFS_CHCTL, 32'h0000_0001);
        set_in(1'b1);
        set_in(1'b0);
        chk_reg(32'(pulses - p0), 32'h0000_0000);
    endtask : t_presc

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        protection_level = 2'h0;
        count_tick = 1'b0;
        filtered_channel_input = 1'b0;
        main_ref = 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_output();
        t_lock();
        t_count();
        t_input(TCPE_MODE_IN, 2'h0, 1, 0, 1'b0);
        t_mode_lock();
        t_input(TCPE_MODE_IN, 2'h1, 0, 1, 1'b1);
        t_input(TCPE_MODE_IN, 2'h3, 1, 1, 1'b0);
        t_input(TCPE_MODE_IN, 2'h2, 0, 0, 1'b0);
        t_input(TCPE_MODE_OUT, 2'h0, 0, 0, 1'b0);
        t_presc();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
